// >>> bscco_core.sv
`timescale 1ns/10ps
// Summary of operation
// - Skip-if-bit-clear skips next instruction when tested file bit is zero.
// - Skip-if-bit-set skips next instruction when tested file bit is one.
// - Taken skip discards prefetched instruction, runs a no-op; two cycles.
// - Bit tests change no flags; bit index 0..7, file address 0..31.
// - Clear accumulator loads zero and sets zero flag only.
// - Call pushes program counter plus one onto the return stack.
// - Call target: literal to PC 7:0, status 6:5 to PC 10:9, PC 8 zero.
// - Call takes two cycles and leaves every status flag unchanged.
// - Clear watchdog resets the watchdog counter to zero.
// - Clear watchdog clears prescaler only while it serves the watchdog.
// - Clear watchdog sets both active-low timeout and power-down flags.
// - Clear file register writes zero to it and sets zero flag.
// - Any program counter write except jump forces PC bit 8 to zero.
module bscco_core
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_instr_valid,
  input wire logic [2:0] i_op,
  input wire logic [bscco_pkg::INSTR_W-1:0] i_instr,
  input wire logic [bscco_pkg::PC_W-1:0] i_pc,
  input wire logic [bscco_pkg::DATA_W-1:0] i_status,
  input wire logic [bscco_pkg::DATA_W-1:0] i_file_rdata,
  input wire logic i_prescaler_to_watchdog,
  output logic o_ready,
  output logic [bscco_pkg::FADDR_W-1:0] o_file_raddr,
  output logic o_file_we,
  output logic [bscco_pkg::FADDR_W-1:0] o_file_waddr,
  output logic [bscco_pkg::DATA_W-1:0] o_file_wdata,
  output logic o_accum_we,
  output logic [bscco_pkg::DATA_W-1:0] o_accum_wdata,
  output logic o_zero_flag_set,
  output logic o_stack_push,
  output logic [bscco_pkg::PC_W-1:0] o_stack_data,
  output logic o_pc_load,
  output logic [bscco_pkg::PC_W-1:0] o_pc_target,
  output logic o_skip_discard,
  output logic o_watchdog_counter_clear,
  output logic o_prescaler_clear,
  output logic o_timeout_flag_n_set,
  output logic o_powerdown_flag_n_set
);

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rstn;

  // Reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rstn = rst_sync2_reg;

  logic [bscco_pkg::FADDR_W-1:0] faddr;
  logic [bscco_pkg::BIDX_W-1:0] bidx;
  logic [bscco_pkg::DATA_W-1:0] literal;

  bscco_field_dec u_field_dec
  (
    .i_instr(i_instr),
    .o_file_addr(faddr),
    .o_bit_idx(bidx),
    .o_literal(literal)
  );

  bscco_pkg::bscco_state_t state_reg;
  bscco_pkg::bscco_state_t state_next;
  logic accept;
  logic tested_bit;

  logic file_we_reg, file_we_next;
  logic [bscco_pkg::FADDR_W-1:0] file_waddr_reg, file_waddr_next;
  logic accum_we_reg, accum_we_next;
  logic zero_set_reg, zero_set_next;
  logic push_reg, push_next;
  logic [bscco_pkg::PC_W-1:0] stack_data_reg, stack_data_next;
  logic pc_load_reg, pc_load_next;
  logic [bscco_pkg::PC_W-1:0] pc_target_reg, pc_target_next;
  logic skip_reg, skip_next;
  logic wdt_clr_reg, wdt_clr_next;
  logic pre_clr_reg, pre_clr_next;
  logic flags_set_reg, flags_set_next;

  assign o_ready = (state_reg == bscco_pkg::ST_IDLE);
  assign accept = o_ready && i_instr_valid;
  assign o_file_raddr = faddr;
  assign tested_bit = i_file_rdata[bidx];

  always_comb
  begin
    state_next = state_reg;
    file_we_next = 1'b0;
    file_waddr_next = file_waddr_reg;
    accum_we_next = 1'b0;
    zero_set_next = 1'b0;
    push_next = 1'b0;
    stack_data_next = stack_data_reg;
    pc_load_next = 1'b0;
    pc_target_next = pc_target_reg;
    skip_next = 1'b0;
    wdt_clr_next = 1'b0;
    pre_clr_next = 1'b0;
    flags_set_next = 1'b0;
    unique case (state_reg)
      bscco_pkg::ST_IDLE:
      begin
        if (accept)
        begin
          unique case (i_op)
            bscco_pkg::OP_SKIP_IF_BIT_CLEAR:
            begin
              skip_next = !tested_bit;
            end
            bscco_pkg::OP_SKIP_IF_BIT_SET:
            begin
              skip_next = tested_bit;
            end
            bscco_pkg::OP_CLEAR_ACCUMULATOR:
            begin
              accum_we_next = 1'b1;
              zero_set_next = 1'b1;
            end
            bscco_pkg::OP_CALL:
            begin
              push_next = 1'b1;
              stack_data_next = i_pc + bscco_pkg::PC_STEP;
              pc_load_next = 1'b1;
              pc_target_next = {i_status[bscco_pkg::STAT_PAGE_LSB +: bscco_pkg::STAT_PAGE_W],
                                1'b0, literal};
            end
            bscco_pkg::OP_CLEAR_WATCHDOG:
            begin
              wdt_clr_next = 1'b1;
              pre_clr_next = i_prescaler_to_watchdog;
              flags_set_next = 1'b1;
            end
            bscco_pkg::OP_CLEAR_FILE_REGISTER:
            begin
              file_we_next = 1'b1;
              file_waddr_next = faddr;
              zero_set_next = 1'b1;
            end
            default:
            begin
              state_next = bscco_pkg::ST_IDLE;
            end
          endcase
          if (skip_next || pc_load_next)
          begin
            state_next = bscco_pkg::ST_NOP;
          end
        end
      end
      bscco_pkg::ST_NOP:
      begin
        state_next = bscco_pkg::ST_IDLE;
      end
      default:
      begin
        state_next = bscco_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= bscco_pkg::ST_IDLE;
      file_we_reg <= 1'b0;
      file_waddr_reg <= bscco_pkg::FADDR_RESET;
      accum_we_reg <= 1'b0;
      zero_set_reg <= 1'b0;
      push_reg <= 1'b0;
      stack_data_reg <= bscco_pkg::PC_RESET;
      pc_load_reg <= 1'b0;
      pc_target_reg <= bscco_pkg::PC_RESET;
      skip_reg <= 1'b0;
      wdt_clr_reg <= 1'b0;
      pre_clr_reg <= 1'b0;
      flags_set_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      file_we_reg <= file_we_next;
      file_waddr_reg <= file_waddr_next;
      accum_we_reg <= accum_we_next;
      zero_set_reg <= zero_set_next;
      push_reg <= push_next;
      stack_data_reg <= stack_data_next;
      pc_load_reg <= pc_load_next;
      pc_target_reg <= pc_target_next;
      skip_reg <= skip_next;
      wdt_clr_reg <= wdt_clr_next;
      pre_clr_reg <= pre_clr_next;
      flags_set_reg <= flags_set_next;
    end
  end

  assign o_file_we = file_we_reg;
  assign o_file_waddr = file_waddr_reg;
  assign o_file_wdata = bscco_pkg::ZERO_BYTE;
  assign o_accum_we = accum_we_reg;
  assign o_accum_wdata = bscco_pkg::ZERO_BYTE;
  assign o_zero_flag_set = zero_set_reg;
  assign o_stack_push = push_reg;
  assign o_stack_data = stack_data_reg;
  assign o_pc_load = pc_load_reg;
  assign o_pc_target = pc_target_reg;
  assign o_skip_discard = skip_reg;
  assign o_watchdog_counter_clear = wdt_clr_reg;
  assign o_prescaler_clear = pre_clr_reg;
  assign o_timeout_flag_n_set = flags_set_reg;
  assign o_powerdown_flag_n_set = flags_set_reg;

  // Checks
  a_skip_on_clear: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_SKIP_IF_BIT_CLEAR) |=> (o_skip_discard == !$past(tested_bit)))
    else $error("skip on clear bit wrong");
  a_skip_on_set: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_SKIP_IF_BIT_SET) |=> (o_skip_discard == $past(tested_bit)))
    else $error("skip on set bit wrong");
  a_skip_two_cycles: assert property (@(posedge i_clk) disable iff (!rstn)
    o_skip_discard |-> (!o_ready ##1 o_ready))
    else $error("skip not two cycles");
  a_test_no_flags: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && (i_op == bscco_pkg::OP_SKIP_IF_BIT_CLEAR || i_op == bscco_pkg::OP_SKIP_IF_BIT_SET))
    |=> !(o_zero_flag_set || o_timeout_flag_n_set || o_file_we || o_accum_we))
    else $error("bit test touched state");
  a_clear_accum: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_CLEAR_ACCUMULATOR)
    |=> (o_accum_we && o_accum_wdata == bscco_pkg::ZERO_BYTE && o_zero_flag_set && !o_timeout_flag_n_set))
    else $error("accumulator clear wrong");
  a_call_push: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_CALL)
    |=> (o_stack_push && o_stack_data == $past(i_pc) + bscco_pkg::PC_STEP))
    else $error("call return address wrong");
  a_call_target: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_CALL) |=> (o_pc_load && o_pc_target[bscco_pkg::DATA_W-1:0] == $past(literal)
    && o_pc_target[bscco_pkg::PC_W-1:bscco_pkg::PC_PAGE_LSB]
    == $past(i_status[bscco_pkg::STAT_PAGE_LSB +: bscco_pkg::STAT_PAGE_W])))
    else $error("call target wrong");
  a_call_timing: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_CALL) |=> (!o_ready && !o_zero_flag_set && !o_timeout_flag_n_set) ##1 o_ready)
    else $error("call timing or flags wrong");
  a_wdt_clear: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_CLEAR_WATCHDOG)
    |=> (o_watchdog_counter_clear
    ##1 (o_watchdog_counter_clear == $past(accept && i_op == bscco_pkg::OP_CLEAR_WATCHDOG))))
    else $error("watchdog clear wrong");
  a_prescaler_gate: assert property (@(posedge i_clk) disable iff (!rstn)
    o_prescaler_clear |-> ($past(i_prescaler_to_watchdog) && o_watchdog_counter_clear))
    else $error("prescaler cleared while on timer");
  a_wdt_flags: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_CLEAR_WATCHDOG) |=> (o_timeout_flag_n_set && o_powerdown_flag_n_set))
    else $error("watchdog flags not set");
  a_clear_file: assert property (@(posedge i_clk) disable iff (!rstn)
    (accept && i_op == bscco_pkg::OP_CLEAR_FILE_REGISTER)
    |=> (o_file_we && o_file_waddr == $past(faddr) && o_file_wdata == bscco_pkg::ZERO_BYTE && o_zero_flag_set))
    else $error("file clear wrong");
  a_pc_bit8: assert property (@(posedge i_clk) disable iff (!rstn)
    o_pc_load |-> !o_pc_target[bscco_pkg::PC_BIT8])
    else $error("pc bit 8 not cleared");

endmodule : bscco_core

// >>> bscco_pkg.sv
package bscco_pkg;

  // Width of the fields handled by the block
  localparam int INSTR_W = 12;
  localparam int PC_W = 11;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int BIDX_W = 3;

  // Operand fields inside the instruction word
  localparam int FADDR_LSB = 0;
  localparam int BIDX_LSB = 5;
  localparam int LIT_LSB = 0;

  // Status register bit positions
  localparam int STAT_Z_BIT = 2;
  localparam int STAT_PAGE_LSB = 5;
  localparam int STAT_PAGE_W = 2;

  // Program counter layout
  localparam int PC_PAGE_LSB = 9;
  localparam int PC_BIT8 = 8;

  // Fixed values
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  localparam logic [PC_W-1:0] PC_STEP = 11'h001;
  localparam logic [FADDR_W-1:0] FADDR_RESET = 5'h00;

  // Operations selected by the instruction decoder
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SKIP_IF_BIT_CLEAR = 3'h1,
    OP_SKIP_IF_BIT_SET = 3'h2,
    OP_CLEAR_ACCUMULATOR = 3'h3,
    OP_CALL = 3'h4,
    OP_CLEAR_WATCHDOG = 3'h5,
    OP_CLEAR_FILE_REGISTER = 3'h6
  } bscco_op_t;

  // Execution states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_NOP = 2'b10
  } bscco_state_t;

endpackage : bscco_pkg

// >>> bscco_field_dec.sv
`timescale 1ns/10ps
module bscco_field_dec
(
  input wire logic [bscco_pkg::INSTR_W-1:0] i_instr,
  output logic [bscco_pkg::FADDR_W-1:0] o_file_addr,
  output logic [bscco_pkg::BIDX_W-1:0] o_bit_idx,
  output logic [bscco_pkg::DATA_W-1:0] o_literal
);

  // Operand extraction
  always_comb
  begin
    o_file_addr = i_instr[bscco_pkg::FADDR_LSB +: bscco_pkg::FADDR_W];
    o_bit_idx = i_instr[bscco_pkg::BIDX_LSB +: bscco_pkg::BIDX_W];
    o_literal = i_instr[bscco_pkg::LIT_LSB +: bscco_pkg::DATA_W];
  end

endmodule : bscco_field_dec

// >>> bscco_core_bench.sv
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module bscco_core_bench;
  typedef struct packed
  {
    logic [2:0] op;
    logic [11:0] instr;
    logic [10:0] pc;
    logic [7:0] status;
    logic [7:0] rdata;
    logic pw;
    logic [9:0] exp;
  } bscco_row_t;
  // Pulse order: skip push load accum zero fwe wdt presc timeout powerdown
  localparam bscco_row_t ROWS [0:11] = '{
    '{3'h1, 12'h071, 11'h010, 8'hff, 8'hf7, 1'b0, 10'h200},
    '{3'h1, 12'h0ff, 11'h011, 8'hff, 8'h80, 1'b0, 10'h000},
    '{3'h2, 12'h000, 11'h012, 8'hff, 8'h01, 1'b0, 10'h200},
    '{3'h2, 12'h0ff, 11'h013, 8'hff, 8'h7f, 1'b0, 10'h000},
    '{3'h3, 12'h000, 11'h014, 8'hff, 8'h00, 1'b0, 10'h060},
    '{3'h4, 12'h9a5, 11'h7ff, 8'h60, 8'h00, 1'b0, 10'h180},
    '{3'h4, 12'hf00, 11'h123, 8'h9f, 8'h00, 1'b0, 10'h180},
    '{3'h5, 12'h000, 11'h020, 8'h00, 8'h00, 1'b1, 10'h00f},
    '{3'h5, 12'h000, 11'h021, 8'h00, 8'h00, 1'b0, 10'h00b},
    '{3'h6, 12'h01f, 11'h022, 8'h00, 8'h00, 1'b0, 10'h030},
    '{3'h7, 12'h0ff, 11'h023, 8'h00, 8'h00, 1'b1, 10'h000},
    '{3'h0, 12'h0ff, 11'h024, 8'h00, 8'h00, 1'b1, 10'h000}
  };
  logic i_clk;
  logic i_resetn;
  logic i_instr_valid;
  logic [2:0] i_op;
  logic [11:0] i_instr;
  logic [10:0] i_pc;
  logic [7:0] i_status;
  logic [7:0] i_file_rdata;
  logic i_prescaler_to_watchdog;
  logic o_ready;
  logic [4:0] o_file_raddr;
  logic o_file_we;
  logic [4:0] o_file_waddr;
  logic [7:0] o_file_wdata;
  logic o_accum_we;
  logic [7:0] o_accum_wdata;
  logic o_zero_flag_set;
  logic o_stack_push;
  logic [10:0] o_stack_data;
  logic o_pc_load;
  logic [10:0] o_pc_target;
  logic o_skip_discard;
  logic o_watchdog_counter_clear;
  logic o_prescaler_clear;
  logic o_timeout_flag_n_set;
  logic o_powerdown_flag_n_set;
  logic exp_skip;
  logic [4:0] last_faddr;
  logic [9:0] pulses;
  int n_errors;
  int comparisons;

  assign pulses = {o_skip_discard, o_stack_push, o_pc_load, o_accum_we, o_zero_flag_set, o_file_we,
    o_watchdog_counter_clear, o_prescaler_clear, o_timeout_flag_n_set, o_powerdown_flag_n_set};

  bscco_core u_dut
  (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_instr_valid(i_instr_valid), .i_op(i_op), .i_instr(i_instr),
    .i_pc(i_pc), .i_status(i_status), .i_file_rdata(i_file_rdata),
    .i_prescaler_to_watchdog(i_prescaler_to_watchdog), .o_ready(o_ready), .o_file_raddr(o_file_raddr),
    .o_file_we(o_file_we), .o_file_waddr(o_file_waddr), .o_file_wdata(o_file_wdata),
    .o_accum_we(o_accum_we), .o_accum_wdata(o_accum_wdata), .o_zero_flag_set(o_zero_flag_set),
    .o_stack_push(o_stack_push), .o_stack_data(o_stack_data), .o_pc_load(o_pc_load),
    .o_pc_target(o_pc_target), .o_skip_discard(o_skip_discard),
    .o_watchdog_counter_clear(o_watchdog_counter_clear), .o_prescaler_clear(o_prescaler_clear),
    .o_timeout_flag_n_set(o_timeout_flag_n_set), .o_powerdown_flag_n_set(o_powerdown_flag_n_set)
  );

  always #4 i_clk = ~i_clk;

  task give_verdict;
    if (n_errors == 0 && comparisons > 0)
    begin
      $display("Run complete: PASS");
    end
    else
    begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Presents one instruction, lets it be taken, then looks after the answer edge
  task take(input bscco_row_t r);
    @(posedge i_clk);
    i_op <= r.op;
    i_instr <= r.instr;
    i_pc <= r.pc;
    i_status <= r.status;
    i_file_rdata <= r.rdata;
    i_prescaler_to_watchdog <= r.pw;
    i_instr_valid <= 1'b1;
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
  endtask : take

  initial
  begin
    #60000;
    n_errors++;
    give_verdict();
  end

  initial
  begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    i_instr_valid = 1'b0;
    i_op = 3'h0;
    i_instr = 12'h000;
    i_pc = 11'h000;
    i_status = 8'h00;
    i_file_rdata = 8'h00;
    i_prescaler_to_watchdog = 1'b0;
    n_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    last_faddr = 5'h00;
    for (int i = 0; i < 12; i++)
    begin
      take(ROWS[i]);
      if (ROWS[i].op == 3'h6)
      begin
        last_faddr = ROWS[i].instr[4:0];
      end
      exp_skip = ROWS[i].rdata[ROWS[i].instr[7:5]] ^ (ROWS[i].op == 3'h1);
      exp_skip = exp_skip && (ROWS[i].op == 3'h1 || ROWS[i].op == 3'h2);
      `CHK("pulses", ROWS[i].exp, pulses)
      `CHK("ready", ~(ROWS[i].exp[9] | ROWS[i].exp[8]), o_ready)
      `CHK("file_raddr", ROWS[i].instr[4:0], o_file_raddr)
      `CHK("bit_idx", exp_skip, o_skip_discard)
      `CHK("waddr_hold", last_faddr, o_file_waddr)
      if (ROWS[i].exp[8])
      begin
        `CHK("stack_data", ROWS[i].pc + 11'h001, o_stack_data)
        `CHK("pc_target", {ROWS[i].status[6:5], 1'b0, ROWS[i].instr[7:0]}, o_pc_target)
        `CHK("pc_low", ROWS[i].instr[7:0], o_pc_target[7:0])
      end
      if (ROWS[i].exp[4])
      begin
        `CHK("file_waddr", ROWS[i].instr[4:0], o_file_waddr)
        `CHK("file_wdata", 8'h00, o_file_wdata)
      end
      if (ROWS[i].exp[6])
      begin
        `CHK("accum_wdata", 8'h00, o_accum_wdata)
      end
    end
    // Back to back clears
    @(posedge i_clk);
    i_op <= 3'h3;
    i_instr_valid <= 1'b1;
    @(posedge i_clk);
    i_op <= 3'h6;
    i_instr <= 12'h00a;
    #1;
    `CHK("b2b_accum", 10'h060, pulses)
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
    `CHK("b2b_file", 10'h030, pulses)
    `CHK("b2b_waddr", 5'h0a, o_file_waddr)
    // Request held through the stall after a call
    @(posedge i_clk);
    i_op <= 3'h4;
    i_instr <= 12'h011;
    i_pc <= 11'h3ff;
    i_status <= 8'h20;
    i_instr_valid <= 1'b1;
    @(posedge i_clk);
    i_op <= 3'h3;
    #1;
    `CHK("stall_ready", 1'b0, o_ready)
    `CHK("stall_target", 11'h211, o_pc_target)
    `CHK("stall_stack", 11'h400, o_stack_data)
    @(posedge i_clk);
    #1;
    `CHK("refused", 10'h000, pulses)
    @(posedge i_clk);
    i_instr_valid <= 1'b0;
    #1;
    `CHK("after_stall", 10'h060, pulses)
    // Reset in mid-run clears held values
    @(posedge i_clk);
    i_resetn <= 1'b0;
    #1;
    `CHK("rst_pulses", 10'h000, pulses)
    `CHK("rst_stack", 11'h000, o_stack_data)
    `CHK("rst_target", 11'h000, o_pc_target)
    `CHK("rst_ready", 1'b1, o_ready)
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    take(ROWS[0]);
    `CHK("rst_skip", 10'h200, pulses)
    give_verdict();
  end
endmodule : bscco_core_bench
